// file: verilog/rtpm_pin_mux.sv
// Pin-function mux for the shared SPI/strap pins, with strap capture and AHB-Lite registers.
// Assumes pin inputs are asynchronous; internal SPI, audio and sync sources run on ref_clk.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rtpm_pin_mux (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [rtpm_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [rtpm_pkg::AHB_DW-1:0] hwdata,
  input wire logic hready,
  output logic [rtpm_pkg::AHB_DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic deviceResetN,
  input wire logic bootSelA,
  input wire logic bootSelB,
  input wire logic testModeIn,
  input wire logic [rtpm_pkg::PROT_W-1:0] protectionIn,
  input wire logic tempMonRefIn,
  output logic tempMonRefOut,
  output logic tempMonRefOe,
  output logic muteOutN,
  output logic muteOutNOe,
  input wire logic volumePulseIn,
  output logic volumePulseOut,
  output logic volumePulseOe,
  input wire logic boardTempIn,
  output logic boardTempOut,
  output logic boardTempOe,
  output logic digitalAudioOut,
  output logic digitalAudioOe,
  input wire logic ampCfgStrap0In,
  output logic faultOutN,
  output logic ampCfgStrap0Oe,
  input wire logic ampCfgStrap1In,
  output logic supplySyncOut,
  output logic ampCfgStrap1Oe,
  input wire logic spiTxSck,
  input wire logic spiTxData,
  output logic spiRxSck,
  output logic spiRxData,
  input wire logic tempRefDrive,
  input wire logic supplySyncSrc,
  input wire logic audioTxData,
  output logic volumeLevel,
  output logic boardTempLevel,
  output logic faultActive,
  output logic [rtpm_pkg::CFG_W-1:0] bootMode,
  output logic [rtpm_pkg::CFG_W-1:0] ampCfg
);
  import rtpm_pkg::*;

  rtpm_state_s r;
  rtpm_state_s n;
  rtpm_pins_s pinsIn;
  logic devUp;
  logic slave;
  logic [CTRL_W-1:0] op;
  logic fault;
  logic addrPhase;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  always_comb begin
    pinsIn.prot = protectionIn;
    pinsIn.cfg1In = ampCfgStrap1In;
    pinsIn.cfg0In = ampCfgStrap0In;
    pinsIn.bootB = bootSelB;
    pinsIn.bootA = bootSelA;
    pinsIn.testIn = testModeIn;
    pinsIn.tempIn = boardTempIn;
    pinsIn.volIn = volumePulseIn;
    pinsIn.refIn = tempMonRefIn;
    pinsIn.devRstN = deviceResetN;
  end

  always_comb begin
    n = r;
    n.s1 = pinsIn;
    n.s2 = r.s1;
    devUp = r.s2.devRstN;
    slave = r.ctrl[SPI_SLAVE];
    // Operating roles only while the device is out of reset and firmware selected them
    op = r.ctrl & {CTRL_W{devUp}};
    fault = r.strapValid & (|(r.s2.prot & PROT_EN[r.ampCfg]));
    ev = '0;
    clr = '0;
    n.devRstPrev = devUp;
    n.volPrev = r.s2.volIn;
    // Straps come through the same synchroniser, so they line up with the reset edge
    if (devUp && !r.devRstPrev) begin
      n.bootMode = {r.s2.bootB, r.s2.bootA};
      n.ampCfg = {r.s2.cfg1In, r.s2.cfg0In};
      n.strapValid = 1'b1;
      ev[EV_STRAP] = 1'b1;
    end
    ev[EV_FAULT] = fault;
    ev[EV_VOL] = op[SEL_VOL] & (r.s2.volIn ^ r.volPrev);
    ev[EV_TEST] = r.s2.testIn;
    // Bus: zero wait state, read data registered at the address-phase edge
    addrPhase = hsel & htrans[1] & hready;
    n.wrPend = addrPhase & hwrite;
    n.wrAddr = haddr[DEC_W-1:0];
    n.hrdata = '0;
    if (addrPhase && !hwrite) begin
      case (haddr[DEC_W-1:0])
        OFS_CTRL: n.hrdata = AHB_DW'(r.ctrl);
        OFS_STRAP: n.hrdata = AHB_DW'({r.strapValid, r.ampCfg, r.bootMode});
        OFS_STAT: n.hrdata = AHB_DW'(r.stat);
        OFS_MASK: n.hrdata = AHB_DW'(r.mask);
        OFS_PINS: n.hrdata = AHB_DW'(r.s2);
        default: n.hrdata = '0;
      endcase
    end
    if (r.wrPend) begin
      case (r.wrAddr)
        OFS_CTRL: n.ctrl = hwdata[CTRL_W-1:0];
        OFS_STAT: clr = hwdata[EV_W-1:0];
        OFS_MASK: n.mask = hwdata[EV_W-1:0];
        default: n.mask = r.mask;
      endcase
    end
    if (!devUp) begin
      n.ctrl = '0;
    end
    // A new event beats a clear written in the same cycle
    n.stat = (r.stat & ~clr) | ev;
    n.irq = |(n.stat & n.mask);
    n.hreadyout = 1'b1;
    // Pin 13: SPI clock after release, temperature reference once selected
    if (op[SEL_REF]) begin
      n.refPad = '{out: tempRefDrive, oe: 1'b1};
    end else if (devUp) begin
      n.refPad = '{out: spiTxSck, oe: !slave};
    end else begin
      n.refPad = '{out: 1'b0, oe: 1'b0};
    end
    n.mutePad = op[SEL_MUTE] ? '{out: !r.ctrl[MUTE_REQ], oe: 1'b1} : '{out: 1'b1, oe: 1'b0};
    // Pins 15/16: SPI data lines until their selects move them to monitor inputs
    n.volPad = '{out: spiTxData, oe: devUp & slave & !op[SEL_VOL]};
    n.tempPad = '{out: spiTxData, oe: devUp & !slave & !op[SEL_TEMP]};
    n.spiRxSck = devUp & slave & !op[SEL_REF] & r.s2.refIn;
    n.spiRxData = slave ? (devUp & !op[SEL_TEMP] & r.s2.tempIn)
                        : (devUp & !op[SEL_VOL] & r.s2.volIn);
    n.volumeLevel = op[SEL_VOL] & r.s2.volIn;
    n.boardTempLevel = op[SEL_TEMP] & r.s2.tempIn;
    n.audioPad = '{out: audioTxData, oe: devUp & r.ctrl[AUDIO_EN]};
    n.faultPad = op[SEL_FAULT] ? '{out: !fault, oe: 1'b1} : '{out: 1'b1, oe: 1'b0};
    n.syncPad = op[SEL_SYNC] ? '{out: supplySyncSrc, oe: 1'b1} : '{out: 1'b0, oe: 1'b0};
    n.faultActive = fault;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.mutePad.out <= 1'b1;
      r.faultPad.out <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = 1'b0;
  assign irq = r.irq;
  assign tempMonRefOut = r.refPad.out;
  assign tempMonRefOe = r.refPad.oe;
  assign muteOutN = r.mutePad.out;
  assign muteOutNOe = r.mutePad.oe;
  assign volumePulseOut = r.volPad.out;
  assign volumePulseOe = r.volPad.oe;
  assign boardTempOut = r.tempPad.out;
  assign boardTempOe = r.tempPad.oe;
  assign digitalAudioOut = r.audioPad.out;
  assign digitalAudioOe = r.audioPad.oe;
  assign faultOutN = r.faultPad.out;
  assign ampCfgStrap0Oe = r.faultPad.oe;
  assign supplySyncOut = r.syncPad.out;
  assign ampCfgStrap1Oe = r.syncPad.oe;
  assign spiRxSck = r.spiRxSck;
  assign spiRxData = r.spiRxData;
  assign volumeLevel = r.volumeLevel;
  assign boardTempLevel = r.boardTempLevel;
  assign faultActive = r.faultActive;
  assign bootMode = r.bootMode;
  assign ampCfg = r.ampCfg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence devRelease;
    !r.s2.devRstN ##1 r.s2.devRstN;
  endsequence

  AST_REF_SPI_CLOCK: assert property (devUp && !r.ctrl[SEL_REF] && !slave |=>
    tempMonRefOe && tempMonRefOut == $past(spiTxSck)) else $error("ref pin not SPI clock");
  AST_REF_TEMP_ROLE: assert property (op[SEL_REF] |=>
    tempMonRefOe && tempMonRefOut == $past(tempRefDrive)) else $error("ref pin not reference");
  AST_MUTE_INPUT_IN_RESET: assert property (!devUp |=> !muteOutNOe)
    else $error("mute pin driven during reset");
  AST_MUTE_LOW: assert property (op[SEL_MUTE] && r.ctrl[MUTE_REQ] |=> muteOutNOe && !muteOutN)
    else $error("mute not driven low");
  AST_VOL_MONITOR: assert property (op[SEL_VOL] |=> !volumePulseOe ##0
    volumeLevel == $past(r.s2.volIn)) else $error("volume pin not monitored");
  AST_MOSI_DRIVE: assert property (devUp && !slave && !op[SEL_TEMP] |=> boardTempOe)
    else $error("MOSI not driven");
  AST_MISO_DRIVE: assert property (devUp && slave && !op[SEL_VOL] |=>
    volumePulseOe && volumePulseOut == $past(spiTxData)) else $error("MISO not driven");
  AST_TEMP_MONITOR: assert property (op[SEL_TEMP] |=> !boardTempOe ##0
    boardTempLevel == $past(r.s2.tempIn)) else $error("temperature pin not monitored");
  AST_AUDIO_FLOAT: assert property (!devUp |=> !digitalAudioOe)
    else $error("audio output driven during reset");
  AST_STRAP_LATCH: assert property (devRelease |=> r.strapValid &&
    r.bootMode == $past({r.s2.bootB, r.s2.bootA}) &&
    r.ampCfg == $past({r.s2.cfg1In, r.s2.cfg0In})) else $error("straps not latched at release");
  AST_CFG_INPUTS: assert property (!devUp |=> !ampCfgStrap0Oe && !ampCfgStrap1Oe)
    else $error("strap pin driven during reset");
  AST_FAULT_LOW: assert property (op[SEL_FAULT] && fault |=> ampCfgStrap0Oe && !faultOutN)
    else $error("fault not driven low");
  AST_SYNC_OUT: assert property (op[SEL_SYNC] |=>
    ampCfgStrap1Oe && supplySyncOut == $past(supplySyncSrc)) else $error("sync not driven");
  AST_PROT_AMP_CFG_STRAP0: assert property (r.strapValid && r.ampCfg == '0 && !r.s2.prot[0] |-> !fault)
    else $error("unwatched protection input caused fault");
  AST_SELECT_CLEAR: assert property (!devUp |=> r.ctrl == '0 ##1 r.ctrl == '0 || devUp)
    else $error("selects not cleared in device reset");
  AST_IRQ_LEVEL: assert property (|(r.stat & r.mask) |-> irq) else $error("irq low with event");

endmodule
`default_nettype wire

// file: verilog/rtpm_pkg.sv
// Constants, field layout and carrier types for the reset-time pin mux.
// Assumes one 250 MHz clock and an AHB-Lite register bus on the same clock.
package rtpm_pkg;

  localparam int AHB_DW = 32;
  localparam int AHB_AW = 32;
  localparam int DEC_W = 8;
  localparam logic [DEC_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [DEC_W-1:0] OFS_STRAP = 8'h04;
  localparam logic [DEC_W-1:0] OFS_STAT = 8'h08;
  localparam logic [DEC_W-1:0] OFS_MASK = 8'h0C;
  localparam logic [DEC_W-1:0] OFS_PINS = 8'h10;

  // Control register fields
  localparam int CTRL_W = 9;
  localparam int SEL_REF = 0;
  localparam int SEL_MUTE = 1;
  localparam int SEL_VOL = 2;
  localparam int SEL_TEMP = 3;
  localparam int SEL_FAULT = 4;
  localparam int SEL_SYNC = 5;
  localparam int AUDIO_EN = 6;
  localparam int MUTE_REQ = 7;
  localparam int SPI_SLAVE = 8;

  // Event bits, shared by status and mask
  localparam int EV_W = 4;
  localparam int EV_FAULT = 0;
  localparam int EV_VOL = 1;
  localparam int EV_STRAP = 2;
  localparam int EV_TEST = 3;

  localparam int PROT_W = 3;
  localparam int CFG_W = 2;
  localparam int AUDIO_MAX_RATE_HZ = 192000;
  // Protection inputs watched per strapped config, indexed by config code
  localparam logic [3:0][PROT_W-1:0] PROT_EN = {3'h7, 3'h5, 3'h3, 3'h1};

  typedef struct packed {
    logic [PROT_W-1:0] prot;
    logic cfg1In;
    logic cfg0In;
    logic bootB;
    logic bootA;
    logic testIn;
    logic tempIn;
    logic volIn;
    logic refIn;
    logic devRstN;
  } rtpm_pins_s;

  typedef struct packed {
    logic out;
    logic oe;
  } rtpm_pad_s;

  typedef struct packed {
    rtpm_pins_s s1;
    rtpm_pins_s s2;
    logic devRstPrev;
    logic volPrev;
    logic [CTRL_W-1:0] ctrl;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [CFG_W-1:0] bootMode;
    logic [CFG_W-1:0] ampCfg;
    logic strapValid;
    logic wrPend;
    logic [DEC_W-1:0] wrAddr;
    logic [AHB_DW-1:0] hrdata;
    logic hreadyout;
    rtpm_pad_s refPad;
    rtpm_pad_s mutePad;
    rtpm_pad_s volPad;
    rtpm_pad_s tempPad;
    rtpm_pad_s audioPad;
    rtpm_pad_s faultPad;
    rtpm_pad_s syncPad;
    logic spiRxSck;
    logic spiRxData;
    logic volumeLevel;
    logic boardTempLevel;
    logic faultActive;
    logic irq;
  } rtpm_state_s;

endpackage

// file: verification/rtpm_board.sv
// Board model for the pin mux: boot and config straps plus test pin.
// Assumes the strap pins read the pull level unless the device drives them.
`timescale 1ns/10ps
`default_nettype none
module rtpm_board (
  input wire logic [1:0] bootCode,
  input wire logic [1:0] cfgCode,
  input wire logic f0Out,
  input wire logic f0Oe,
  input wire logic f1Out,
  input wire logic f1Oe,
  output logic bootSelA,
  output logic bootSelB,
  output logic testModeIn,
  output logic strap0,
  output logic strap1
);
  assign testModeIn = 1'b0;
  assign {bootSelB, bootSelA} = bootCode;
  // The pull only wins while the device leaves the pin alone
  assign strap0 = f0Oe ? f0Out : cfgCode[0];
  assign strap1 = f1Oe ? f1Out : cfgCode[1];
endmodule
`default_nettype wire

// file: verification/tb_reset_time_pin_function_mux.sv
// Self-checking bench for the pin mux: straps, pin roles, fault and interrupt.
// Assumes one clock and an AHB-Lite master with zero-wait answers.
`timescale 1ns/10ps
`default_nettype none
module tb_reset_time_pin_function_mux;
  import rtpm_pkg::*;
  logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, devRstN = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, prot = 0;
  logic spiSck = 1, spiDat = 1, refDrv = 0, syncSrc = 1, audTx = 0;
  logic hreadyout, irq, refOut, refOe, muteN, muteOe, volOut, volOe, tmpOut, tmpOe;
  logic audOut, audOe, f0Out, f0Oe, f1Out, f1Oe, fltAct, bA, bB, tst, s0, s1;
  logic [1:0] bootMode, ampCfg;
  logic [1:0] bootC = 2'b10, cfgC = 2'b00;
  logic refIn = 0, volIn = 1, tmpIn = 0, volLvl, tmpLvl, rxSck, rxDat;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  assign hready = hreadyout;
  rtpm_board i_board (.bootCode(bootC), .cfgCode(cfgC), .f0Out(f0Out), .f0Oe(f0Oe),
    .f1Out(f1Out), .f1Oe(f1Oe), .bootSelA(bA), .bootSelB(bB), .testModeIn(tst),
    .strap0(s0), .strap1(s1));
  rtpm_pin_mux i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .irq(irq), .deviceResetN(devRstN),
    .bootSelA(bA), .bootSelB(bB), .testModeIn(tst), .protectionIn(prot),
    .tempMonRefIn(refOe ? refOut : refIn), .tempMonRefOut(refOut), .tempMonRefOe(refOe),
    .muteOutN(muteN), .muteOutNOe(muteOe), .volumePulseIn(volOe ? volOut : volIn),
    .volumePulseOut(volOut), .volumePulseOe(volOe), .boardTempIn(tmpOe ? tmpOut : tmpIn),
    .boardTempOut(tmpOut), .boardTempOe(tmpOe), .digitalAudioOut(audOut),
    .digitalAudioOe(audOe), .ampCfgStrap0In(s0), .faultOutN(f0Out), .ampCfgStrap0Oe(f0Oe),
    .ampCfgStrap1In(s1), .supplySyncOut(f1Out), .ampCfgStrap1Oe(f1Oe), .spiTxSck(spiSck),
    .spiTxData(spiDat), .spiRxSck(rxSck), .spiRxData(rxDat), .tempRefDrive(refDrv),
    .supplySyncSrc(syncSrc), .audioTxData(audTx), .volumeLevel(volLvl), .boardTempLevel(tmpLvl),
    .faultActive(fltAct), .bootMode(bootMode), .ampCfg(ampCfg));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task final_report;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Single transfer; waits for hready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task t_strap;
    chk({refOe, muteOe, volOe, tmpOe, audOe, f0Oe, f1Oe, muteN}, 8'h01);
    devRstN <= 1;
    repeat (6) @(posedge ref_clk);
    chk({bootMode, ampCfg}, 4'b1000);
    chk({refOe, tmpOe, volOe, refOut, tmpOut}, 5'b11011);
    ahb(0, OFS_STRAP, 0);
    chk(q, 32'h12);
    ahb(0, 8'h20, 0);
    chk(q, 32'h0);
  endtask
  task t_roles;
    ahb(1, OFS_CTRL, 32'hFF);
    repeat (2) @(posedge ref_clk);
    chk({refOe, muteOe, volOe, tmpOe, audOe, f0Oe, f1Oe}, 7'b1100111);
    chk({refOut, muteN, f0Out, f1Out, audOut}, 5'b00110);
    refDrv <= 1;
    syncSrc <= 0;
    audTx <= 1;
    ahb(1, OFS_CTRL, 32'h7F);
    repeat (2) @(posedge ref_clk);
    chk({refOut, muteN, f1Out, audOut}, 4'b1101);
  endtask
  task t_fault;
    prot <= 3'b010;
    repeat (5) @(posedge ref_clk);
    chk(f0Out, 1);
    prot <= 3'b001;
    repeat (5) @(posedge ref_clk);
    chk({f0Out, fltAct}, 2'b01);
    prot <= 3'b000;
    repeat (5) @(posedge ref_clk);
    chk(f0Out, 1);
    ahb(1, OFS_MASK, 32'h1 << EV_STRAP);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1);
    ahb(1, OFS_STAT, 32'h1 << EV_STRAP);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    ahb(0, OFS_STAT, 0);
    chk(q, 32'h1 << EV_FAULT);
  endtask
  // Monitor roles: volume and temperature pins read back as levels, the volume pin also as an event
  task t_monitor;
    volIn <= 0;
    tmpIn <= 1;
    repeat (5) @(posedge ref_clk);
    chk({volLvl, tmpLvl}, 2'b01);
    ahb(0, OFS_STAT, 0);
    chk(q, 32'h3);
  endtask
  // Second device reset with new straps: pins fall back, selects clear, straps relatch
  task t_rearm;
    devRstN <= 0;
    bootC <= 2'b01;
    cfgC <= 2'b01;
    repeat (4) @(posedge ref_clk);
    chk({refOe, muteOe, volOe, tmpOe, audOe, f0Oe, f1Oe, muteN}, 8'h01);
    ahb(0, OFS_CTRL, 0);
    chk(q, 32'h0);
    devRstN <= 1;
    repeat (6) @(posedge ref_clk);
    chk({bootMode, ampCfg}, 4'b0101);
    prot <= 3'b010;
    repeat (5) @(posedge ref_clk);
    chk({f0Oe, fltAct}, 2'b01);
    prot <= 3'b000;
  endtask
  // Slave mode: clock and data come in, the volume pin drives data out
  task t_slave;
    ahb(1, OFS_CTRL, 32'h1 << SPI_SLAVE);
    refIn <= 1;
    spiDat <= 0;
    repeat (5) @(posedge ref_clk);
    chk({refOe, volOe, tmpOe, volOut, rxSck, rxDat}, 6'b010011);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    t_strap;
    t_roles;
    t_fault;
    t_monitor;
    t_rearm;
    t_slave;
    final_report;
  end
endmodule
`default_nettype wire
